//--- spas_defs.svh
`ifndef SPAS_DEFS_SVH
`define SPAS_DEFS_SVH
// Operation
// - open strap means i2c, resistor means rs485
// - answer address 100 plus four configured bits
// - address byte lsb zero writes, one reads
// - accept broadcast address zero, act together
// - broadcast read raises invalid command
// - unit position voltage gives ten codes
// - rack position voltage gives eight codes
// - unit 1-4 rack 1-4 address map
// - unit 1-5 rack 6-8 address map
// - units 6-7 and 8-10 address maps
// - slot interlock gates output power
// - rs485 address is bay, slot, shelf
// - slot voltage gives ten codes, 3.3V none
// - shelf voltage windows give ten codes
// - voltage change command finishes within 60ms
// - software command overrides setpoint pin permanently
// - bias power recycle restores pin control
// - setpoint pin spans 23 to 65 volts
// - pin above 3V or below 0.1V gives 23V
// - rs485 mode ignores the on/off pin

// ****************************************************************
// sampling and code widths
// ****************************************************************
`define SPAS_ADC_W 10
`define SPAS_CODE_W 4
// strap settle wait after reset release, cycles
`define SPAS_STRAP_SETTLE 4'h3

// ****************************************************************
// quantiser windows, 310 counts per volt for unit and rack, code 1 in the low slot
// ****************************************************************
`define SPAS_UNIT_LO {10'h000, 10'h038, 10'h0A3, 10'h109, 10'h16F, \
	10'h1D6, 10'h23C, 10'h2A2, 10'h309, 10'h36F}
`define SPAS_UNIT_HI {10'h037, 10'h0A2, 10'h108, 10'h16E, 10'h1D5, \
	10'h23B, 10'h2A1, 10'h308, 10'h36E, 10'h3D0}
`define SPAS_RACK_LO {10'h000, 10'h04E, 10'h0E9, 10'h174, 10'h1F0, \
	10'h27C, 10'h317, 10'h3B2}
`define SPAS_RACK_HI {10'h04D, 10'h0E8, 10'h173, 10'h1EF, 10'h27B, \
	10'h316, 10'h3B1, 10'h3FF}
// shelf input uses a 33V full scale, 31 counts per volt
`define SPAS_SHELF_LO {10'h2E2, 10'h295, 10'h24D, 10'h203, 10'h1B9, \
	10'h16E, 10'h127, 10'h0E6, 10'h092, 10'h048}
`define SPAS_SHELF_HI {10'h32F, 10'h2DB, 10'h28B, 10'h23A, 10'h1E9, \
	10'h199, 10'h145, 10'h0EB, 10'h0A4, 10'h053}

// ****************************************************************
// position codes and setpoint constants
// ****************************************************************
`define SPAS_CODE_NONE 4'h0
`define SPAS_SLOT_SHORT 4'hA
`define SPAS_VSET_PIN_LO 10'h01F
`define SPAS_VSET_PIN_HI 10'h3A2
`define SPAS_VSET_DEFAULT_MV 16'h59D8
`define SPAS_VSET_SLOPE_Q8 14'h2EB8
`define SPAS_CFG_ADDR_TOP 3'h4
`endif

//--- spas_pkg.sv
package spas_pkg;
	// communications mode fixed by the strap
	typedef enum logic {SPAS_MODE_I2C, SPAS_MODE_RS485} spas_mode_t;
	// strap capture phase
	typedef enum logic [1:0] {SPAS_PH_SETTLE, SPAS_PH_RUN} spas_phase_t;
	typedef logic [3:0] spas_code_t;
	typedef logic [9:0] spas_sample_t;
endpackage

//--- spas_code_if.sv
`timescale 1ns/1ps
`default_nettype none
// sample in, position code out, between top and quantiser
interface spas_code_if;
	spas_pkg::spas_sample_t sample;
	spas_pkg::spas_code_t code;
	modport quant (input sample, output code);
	modport user (output sample, input code);
endinterface
`default_nettype wire

//--- spas_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "spas_defs.svh"
// two stage synchroniser for pin level inputs
module spas_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q; // first stage, read only by the second
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_d;

	generate
		if (W < 1) begin : g_chk
			$error("spas_sync width must be at least one");
		end
	endgenerate

	// next values are just the shift
	always_comb begin
		meta_d = d;
		sync_d = meta_q;
	end

	// register both stages
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= meta_d;
			q <= sync_d;
		end
	end
endmodule
`default_nettype wire

//--- spas_level_quant.sv
`timescale 1ns/1ps
`default_nettype none
`include "spas_defs.svh"
// window quantiser: code k when sample lies in window k, else none
module spas_level_quant #(
	parameter int NC = 10,
	parameter logic [NC*10-1:0] LO = '0,
	parameter logic [NC*10-1:0] HI = '0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// sample and code
	spas_code_if.quant cif
);
	spas_pkg::spas_code_t code_d;

	generate
		if (NC < 1 || NC > 15) begin : g_chk
			$error("spas_level_quant needs 1 to 15 codes");
		end
	endgenerate

	// windows may leave gaps; a gap reads as no code
	always_comb begin
		code_d = `SPAS_CODE_NONE;
		for (int k = 0; k < NC; k++) begin
			if (cif.sample >= LO[k*10 +: 10] && cif.sample <= HI[k*10 +: 10]) begin
				code_d = 4'(k + 1);
			end
		end
	end

	// registered code
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cif.code <= `SPAS_CODE_NONE;
		end else begin
			cif.code <= code_d;
		end
	end
endmodule
`default_nettype wire

//--- spas_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "spas_defs.svh"
// address, interlock and setpoint selection of the supply controller
module spas_top (
	// clock and reset (reset is controller bias power)
	input wire logic mclk,
	input wire logic reset_n,
	// digitised position pins, asynchronous
	input wire logic [9:0] unit_pos_sample,
	input wire logic [9:0] rack_pos_sample,
	input wire logic [9:0] slot_pos_sample,
	input wire logic [9:0] shelf_pos_sample,
	input wire logic [9:0] setpoint_pin_sample,
	// control pins, asynchronous
	input wire logic protocol_strap_low,
	input wire logic on_off_n,
	// address byte from serial front end, same clock
	input wire logic addr_byte_valid,
	input wire logic [7:0] addr_byte,
	// software voltage command, same clock
	input wire logic vout_cmd_valid,
	input wire logic [15:0] vout_cmd_mv,
	// mode and addresses
	output logic mode_rs485,
	output logic [3:0] configured_address_bits,
	output logic address_config_valid,
	output logic [3:0] bay_position_code,
	output logic [3:0] slot_position_code,
	output logic [3:0] shelf_position_code,
	output logic rs485_address_valid,
	// address decode answer
	output logic addr_match,
	output logic addr_broadcast,
	output logic addr_read,
	output logic invalid_command,
	// power and setpoint
	output logic power_enable,
	output logic [15:0] setpoint_mv,
	output logic setpoint_sw_override,
	output logic setpoint_update
);
	// ****************************************************************
	// pin synchronisation
	// ****************************************************************
	logic [51:0] pins_raw; // all asynchronous pins
	logic [51:0] pins_s; // after two flops
	logic strap_s; // strap level, synchronised
	logic on_off_n_s; // on/off level, synchronised
	spas_pkg::spas_sample_t setp_s; // setpoint sample, synchronised

	assign pins_raw = {protocol_strap_low, on_off_n, setpoint_pin_sample,
		shelf_pos_sample, slot_pos_sample, rack_pos_sample, unit_pos_sample};

	spas_sync #(.W(52)) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.d(pins_raw),
		.q(pins_s)
	);

	assign strap_s = pins_s[51];
	assign on_off_n_s = pins_s[50];
	assign setp_s = pins_s[49:40];

	// ****************************************************************
	// position quantisers
	// ****************************************************************
	spas_code_if unit_if ();
	spas_code_if rack_if ();
	spas_code_if slot_if ();
	spas_code_if shelf_if ();

	assign unit_if.sample = pins_s[9:0];
	assign rack_if.sample = pins_s[19:10];
	assign slot_if.sample = pins_s[29:20];
	assign shelf_if.sample = pins_s[39:30];

	// unit and slot share the ten-level divider table
	spas_level_quant #(.NC(10), .LO(`SPAS_UNIT_LO), .HI(`SPAS_UNIT_HI)) u_unit_q (
		.mclk(mclk),
		.reset_n(reset_n),
		.cif(unit_if)
	);
	spas_level_quant #(.NC(8), .LO(`SPAS_RACK_LO), .HI(`SPAS_RACK_HI)) u_rack_q (
		.mclk(mclk),
		.reset_n(reset_n),
		.cif(rack_if)
	);
	spas_level_quant #(.NC(10), .LO(`SPAS_UNIT_LO), .HI(`SPAS_UNIT_HI)) u_slot_q (
		.mclk(mclk),
		.reset_n(reset_n),
		.cif(slot_if)
	);
	spas_level_quant #(.NC(10), .LO(`SPAS_SHELF_LO), .HI(`SPAS_SHELF_HI)) u_shelf_q (
		.mclk(mclk),
		.reset_n(reset_n),
		.cif(shelf_if)
	);

	// ****************************************************************
	// strap capture and mode
	// ****************************************************************
	spas_pkg::spas_phase_t phase_q, phase_d;
	spas_pkg::spas_mode_t mode_q, mode_d;
	logic [3:0] settle_q, settle_d; // waits out the synchroniser fill

	// mode is caught once after release; a strap change needs a bias recycle
	always_comb begin
		phase_d = phase_q;
		mode_d = mode_q;
		settle_d = settle_q;
		case (phase_q)
			spas_pkg::SPAS_PH_SETTLE: begin
				if (settle_q == `SPAS_STRAP_SETTLE) begin
					phase_d = spas_pkg::SPAS_PH_RUN;
					// resistor to return pulls the strap low
					mode_d = strap_s ? spas_pkg::SPAS_MODE_RS485 : spas_pkg::SPAS_MODE_I2C;
				end else begin
					settle_d = settle_q + 4'h1;
				end
			end
			spas_pkg::SPAS_PH_RUN: begin
				phase_d = phase_q;
			end
			default: begin
				phase_d = spas_pkg::SPAS_PH_SETTLE;
			end
		endcase
	end

	// register phase and mode
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q <= spas_pkg::SPAS_PH_SETTLE;
			mode_q <= spas_pkg::SPAS_MODE_I2C;
			settle_q <= 4'h0;
		end else begin
			phase_q <= phase_d;
			mode_q <= mode_d;
			settle_q <= settle_d;
		end
	end

	logic run; // mode valid
	logic rs485; // rs485 mode in force
	assign run = (phase_q == spas_pkg::SPAS_PH_RUN);
	assign rs485 = run && (mode_q == spas_pkg::SPAS_MODE_RS485);

	// ****************************************************************
	// address configuration
	// ****************************************************************
	// returns {valid, address bits}; pairs outside every map are unassigned
	function automatic logic [4:0] spas_map(input logic [3:0] u, input logic [3:0] r);
		logic [7:0] a;
		logic v;
		a = 8'h00;
		v = 1'b0;
		if (u >= 4'h1 && u <= 4'h4 && r >= 4'h1 && r <= 4'h4) begin
			a = 8'(({4'h0, r} - 8'h01) * 8'h04 + ({4'h0, u} - 8'h01));
			v = 1'b1;
		end else if (u >= 4'h1 && u <= 4'h5 && r >= 4'h6 && r <= 4'h8) begin
			a = 8'(({4'h0, r} - 8'h06) * 8'h05 + ({4'h0, u} - 8'h01));
			v = 1'b1;
		end else if (u >= 4'h6 && u <= 4'h7 && r >= 4'h1 && r <= 4'h8) begin
			a = 8'(({4'h0, r} - 8'h01) * 8'h02 + ({4'h0, u} - 8'h06));
			v = 1'b1;
		end else if (u >= 4'h8 && u <= 4'hA && r >= 4'h4 && r <= 4'h8) begin
			a = 8'(({4'h0, r} - 8'h04) * 8'h03 + ({4'h0, u} - 8'h08));
			v = 1'b1;
		end
		return {v, a[3:0]};
	endfunction

	logic [4:0] map_w; // mapped address of current codes
	logic [3:0] cab_d;
	logic cab_v_d;
	logic [3:0] bay_d, slot_d, shelf_d;
	logic rs_v_d;
	logic ilk_ok; // slot interlock satisfied
	logic pwr_d;

	// address, rs485 parts and power gating
	always_comb begin
		map_w = spas_map(unit_if.code, rack_if.code);
		cab_d = map_w[3:0];
		cab_v_d = map_w[4];
		bay_d = unit_if.code;
		slot_d = slot_if.code;
		shelf_d = shelf_if.code;
		rs_v_d = (bay_d != `SPAS_CODE_NONE) && (slot_d != `SPAS_CODE_NONE) &&
			(shelf_d != `SPAS_CODE_NONE);
		// i2c needs a short; in rs485 any slot resistor senses the interlock
		ilk_ok = rs485 ? (slot_if.code != `SPAS_CODE_NONE) :
			(slot_if.code == `SPAS_SLOT_SHORT);
		pwr_d = run && ilk_ok && (rs485 || !on_off_n_s);
	end

	// register address and power outputs
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			configured_address_bits <= 4'h0;
			address_config_valid <= 1'b0;
			bay_position_code <= `SPAS_CODE_NONE;
			slot_position_code <= `SPAS_CODE_NONE;
			shelf_position_code <= `SPAS_CODE_NONE;
			rs485_address_valid <= 1'b0;
			power_enable <= 1'b0;
		end else begin
			configured_address_bits <= cab_d;
			address_config_valid <= cab_v_d;
			bay_position_code <= bay_d;
			slot_position_code <= slot_d;
			shelf_position_code <= shelf_d;
			rs485_address_valid <= rs_v_d;
			power_enable <= pwr_d;
		end
	end

	assign mode_rs485 = rs485;

	// ****************************************************************
	// i2c address decode
	// ****************************************************************
	logic own_hit, bc_hit; // address byte hits
	logic match_d, bcast_d, read_d, inval_d;

	// compares against the registered address, one cycle behind the codes
	always_comb begin
		own_hit = addr_byte_valid && run && !rs485 && address_config_valid &&
			(addr_byte[7:5] == `SPAS_CFG_ADDR_TOP) &&
			(addr_byte[4:1] == configured_address_bits);
		bc_hit = addr_byte_valid && run && !rs485 && (addr_byte[7:1] == 7'h00);
		match_d = own_hit || bc_hit;
		bcast_d = bc_hit;
		read_d = match_d && addr_byte[0];
		inval_d = bc_hit && addr_byte[0];
	end

	// one-cycle answer pulses
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			addr_match <= 1'b0;
			addr_broadcast <= 1'b0;
			addr_read <= 1'b0;
			invalid_command <= 1'b0;
		end else begin
			addr_match <= match_d;
			addr_broadcast <= bcast_d;
			addr_read <= read_d;
			invalid_command <= inval_d;
		end
	end

	// ****************************************************************
	// setpoint selection
	// ****************************************************************
	logic ovr_d; // software has taken over
	logic [15:0] sw_mv_q, sw_mv_d;
	logic [9:0] pin_off; // pin sample above the low knee
	logic [23:0] prod; // offset times slope, q8
	logic [15:0] pin_mv; // analog setpoint
	logic [15:0] sp_d;

	// only reset, i.e. a bias recycle, gives the pin back
	always_comb begin
		ovr_d = setpoint_sw_override || vout_cmd_valid;
		sw_mv_d = vout_cmd_valid ? vout_cmd_mv : sw_mv_q;
		pin_off = setp_s - `SPAS_VSET_PIN_LO;
		prod = {14'h0000, pin_off} * {10'h000, `SPAS_VSET_SLOPE_Q8};
		if (setp_s < `SPAS_VSET_PIN_LO || setp_s > `SPAS_VSET_PIN_HI) begin
			pin_mv = `SPAS_VSET_DEFAULT_MV;
		end else begin
			pin_mv = `SPAS_VSET_DEFAULT_MV + prod[23:8];
		end
		// command takes effect on the next edge, far inside 60ms
		sp_d = ovr_d ? sw_mv_d : pin_mv;
	end

	// register setpoint state
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			setpoint_sw_override <= 1'b0;
			sw_mv_q <= `SPAS_VSET_DEFAULT_MV;
			setpoint_mv <= `SPAS_VSET_DEFAULT_MV;
			setpoint_update <= 1'b0;
		end else begin
			setpoint_sw_override <= ovr_d;
			sw_mv_q <= sw_mv_d;
			setpoint_mv <= sp_d;
			setpoint_update <= (sp_d != setpoint_mv);
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_mode_fixed: assert property (run |=> $stable(mode_rs485))
		else $error("mode changed after capture");
	a_own_match: assert property (addr_byte_valid && run && !rs485 &&
		address_config_valid && addr_byte[7:5] == 3'h4 && addr_byte[4:1] == configured_address_bits
		|=> addr_match && addr_read == $past(addr_byte[0]))
		else $error("own address not answered");
	a_bcast_accept: assert property (addr_byte_valid && run && !rs485 &&
		addr_byte[7:1] == 7'h00 |=> addr_match && addr_broadcast)
		else $error("broadcast not accepted");
	a_bcast_read: assert property (invalid_command |-> addr_broadcast && addr_read)
		else $error("invalid command without broadcast read");
	a_rs485_silent: assert property (rs485 ##1 rs485 |-> !addr_match)
		else $error("i2c answer in rs485 mode");
	a_map_corner: assert property (unit_if.code == 4'h4 && rack_if.code == 4'h4
		|=> address_config_valid && configured_address_bits == 4'hF)
		else $error("unit 4 rack 4 mapped wrong");
	a_map_high: assert property (unit_if.code == 4'hA && rack_if.code == 4'h8
		|=> address_config_valid && configured_address_bits == 4'hE)
		else $error("unit 10 rack 8 mapped wrong");
	a_map_gap: assert property (rack_if.code == 4'h5 && unit_if.code >= 4'h1 &&
		unit_if.code <= 4'h5 |=> !address_config_valid)
		else $error("rack 5 low units not unassigned");
	a_power_gate: assert property (power_enable |-> $past(run) && ($past(rs485) ||
		($past(slot_if.code) == 4'hA && !$past(on_off_n_s))) && $past(slot_if.code) != 4'h0)
		else $error("power without interlock");
	a_onoff_ignore: assert property (rs485 && slot_if.code != 4'h0 |=> power_enable)
		else $error("rs485 power held off");
	a_override_keep: assert property (setpoint_sw_override |=> setpoint_sw_override)
		else $error("override dropped");
	a_override_pin: assert property (setpoint_sw_override && !vout_cmd_valid
		|=> $stable(setpoint_mv))
		else $error("pin moved software setpoint");
	a_cmd_apply: assert property (vout_cmd_valid |=> setpoint_mv == $past(vout_cmd_mv))
		else $error("command not applied");
	a_pin_default: assert property (!setpoint_sw_override && !vout_cmd_valid &&
		(setp_s < 10'h01F || setp_s > 10'h3A2) |=> setpoint_mv == 16'h59D8)
		else $error("out of band pin not 23V");

	c_bcast_write: cover property (addr_match && addr_broadcast && !addr_read);
	c_bcast_read: cover property (invalid_command);
	c_override: cover property (!setpoint_sw_override ##1 setpoint_sw_override);
	c_rs485_power: cover property (rs485 && power_enable);
endmodule
`default_nettype wire

//--- spas_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host controller: hands over address bytes and voltage commands
// ****************************************
module spas_host (
	// clock
	input wire logic mclk,
	// address byte from the serial front end
	output logic addr_byte_valid,
	output logic [7:0] addr_byte,
	// software voltage command
	output logic vout_cmd_valid,
	output logic [15:0] vout_cmd_mv
);
	// idle values, no request pending
	initial begin
		addr_byte_valid = 1'b0;
		addr_byte = 8'hA5;
		vout_cmd_valid = 1'b0;
		vout_cmd_mv = 16'h5A5A;
	end
	// one address byte for one cycle, changed at the falling edge
	task automatic send_addr(input logic [6:0] addr, input logic rd);
		@(negedge mclk);
		addr_byte_valid = 1'b1;
		addr_byte = {addr, rd};
		@(negedge mclk);
		addr_byte_valid = 1'b0;
		// stale byte inverted so a late look cannot pass
		addr_byte = ~addr_byte;
	endtask
	// one executed voltage command
	task automatic send_cmd(input logic [15:0] mv);
		@(negedge mclk);
		vout_cmd_valid = 1'b1;
		vout_cmd_mv = mv;
		@(negedge mclk);
		vout_cmd_valid = 1'b0;
		vout_cmd_mv = ~vout_cmd_mv;
	endtask
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ****************************************
	// pins, counters and model state
	// ****************************************
	logic mclk = 1'b0; // 200 MHz
	logic reset_n = 1'b0; // bias power off at start
	logic [9:0] unit_pos_sample = 10'h000; // position voltages
	logic [9:0] rack_pos_sample = 10'h000;
	logic [9:0] slot_pos_sample = 10'h000;
	logic [9:0] shelf_pos_sample = 10'h000;
	logic [9:0] setpoint_pin_sample = 10'h000;
	logic protocol_strap_low = 1'b0; // open strap
	logic on_off_n = 1'b1; // output off
	logic addr_byte_valid, vout_cmd_valid; // driven by the host model
	logic [7:0] addr_byte;
	logic [15:0] vout_cmd_mv, setpoint_mv;
	logic mode_rs485, address_config_valid, rs485_address_valid;
	logic addr_match, addr_broadcast, addr_read, invalid_command;
	logic power_enable, setpoint_sw_override, setpoint_update;
	logic [3:0] configured_address_bits, bay_position_code;
	logic [3:0] slot_position_code, shelf_position_code;
	int mismatches = 0;
	int n_checks = 0;
	int seed = 32'h045F9A38;
	int cycles = 0;
	int rack_mv[8] = '{3300, 2800, 2300, 1800, 1400, 1000, 500, 0}; // nominal levels
	int q[$]; // pending setpoint pin samples
	int a, s, mv;
	logic rd;
	// free running clock
	always #2.5 mclk = ~mclk;
	spas_top dut (.mclk, .reset_n, .unit_pos_sample, .rack_pos_sample, .slot_pos_sample,
		.shelf_pos_sample, .setpoint_pin_sample, .protocol_strap_low, .on_off_n,
		.addr_byte_valid, .addr_byte, .vout_cmd_valid, .vout_cmd_mv, .mode_rs485,
		.configured_address_bits, .address_config_valid, .bay_position_code,
		.slot_position_code, .shelf_position_code, .rs485_address_valid, .addr_match,
		.addr_broadcast, .addr_read, .invalid_command, .power_enable, .setpoint_mv,
		.setpoint_sw_override, .setpoint_update);
	spas_host host (.mclk, .addr_byte_valid, .addr_byte, .vout_cmd_valid, .vout_cmd_mv);
	// ****************************************
	// reference model, counts at 310 per volt
	// ****************************************
	// unit and slot code k, 11 gives the invalid 3.3V level
	function automatic int unit_cnt(int k);
		return (k > 10) ? 1010 : (3000 - 330 * (k - 1)) * 31 / 100;
	endfunction
	// address bits of a unit and rack pair, -1 when unassigned
	function automatic int addr_of(int u, int r);
		if (u <= 4 && r <= 4) return (r - 1) * 4 + u - 1;
		if (u <= 5 && r >= 6) return (r - 6) * 5 + u - 1;
		if (u == 6 || u == 7) return (r - 1) * 2 + u - 6;
		if (u >= 8 && r >= 4) return (r - 4) * 3 + u - 8;
		return -1;
	endfunction
	// setpoint from the pin, default outside the linear span
	function automatic int sp_exp(int v);
		return (v >= 31 && v <= 930) ? 23000 + (((v - 31) * 11960) >> 8) : 23000;
	endfunction
	// ****************************************
	// compare, wait and closing tasks
	// ****************************************
	task automatic fail(input logic [15:0] got, input logic [15:0] exp);
		mismatches++;
		$display("unexpected at %0t ns: got %0h expected %0h", $time, got, exp);
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) fail(16'(got), 16'(exp));
	endtask
	task automatic chk_code(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) fail(16'(got), 16'(exp));
	endtask
	task automatic chk_mv(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) fail(got, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// bias power recycle, strap set while power is off
	task automatic power_cycle(input logic strap);
		@(negedge mclk);
		reset_n = 1'b0;
		protocol_strap_low = strap;
		tick(3);
		reset_n = 1'b1;
		tick(10);
	endtask
	task automatic power_case(input int slot, input logic off_n, input logic exp);
		slot_pos_sample = 10'(unit_cnt(slot));
		on_off_n = off_n;
		tick(6);
		chk_flag(power_enable, exp);
	endtask
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// hang guard, the run needs about 900 cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			report_and_stop();
		end
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		power_cycle(1'b0);
		chk_flag(mode_rs485, 1'b0);
		// every unit and rack pair, own address with random direction
		for (int r = 1; r <= 8; r++) begin
			for (int u = 1; u <= 10; u++) begin
				a = addr_of(u, r);
				unit_pos_sample = 10'(unit_cnt(u));
				rack_pos_sample = 10'(rack_mv[r - 1] * 31 / 100);
				tick(6);
				chk_flag(address_config_valid, a >= 0);
				if (a >= 0) chk_code(configured_address_bits, 4'(a));
				rd = 1'($random(seed));
				host.send_addr({3'h4, 4'(a)}, rd);
				chk_flag(addr_match, a >= 0);
				chk_flag(addr_read, a >= 0 && rd);
				chk_flag(addr_broadcast, 1'b0);
			end
		end
		$display("test address map done");
		// unit 3 rack 2 gives 0110: foreign address, broadcasts, readback
		unit_pos_sample = 10'(unit_cnt(3));
		rack_pos_sample = 10'(rack_mv[1] * 31 / 100);
		tick(6);
		host.send_addr(7'h47, 1'b0);
		chk_flag(addr_match, 1'b0);
		host.send_addr(7'h00, 1'b0);
		chk_flag(addr_broadcast, 1'b1);
		chk_flag(invalid_command, 1'b0);
		host.send_addr(7'h00, 1'b1);
		chk_flag(invalid_command, 1'b1);
		host.send_addr(7'h46, 1'b1);
		chk_flag(addr_match, 1'b1);
		unit_pos_sample = 10'(unit_cnt(11));
		tick(6);
		chk_flag(address_config_valid, 1'b0);
		$display("test broadcast done");
		// interlock and on/off pin in i2c mode
		power_case(10, 1'b0, 1'b1);
		power_case(10, 1'b1, 1'b0);
		power_case(5, 1'b0, 1'b0);
		$display("test i2c power done");
		// pin setpoint, random samples and span edges
		for (int i = 0; i < 12; i++) q.push_back($unsigned($random(seed)) % 1024);
		q.push_back(30);
		q.push_back(31);
		q.push_back(931);
		q.push_back(930);
		while (q.size() > 0) begin
			s = q.pop_front();
			setpoint_pin_sample = 10'(s);
			tick(6);
			chk_mv(setpoint_mv, 16'(sp_exp(s)));
		end
		// software command takes over, repeat brings no change
		mv = 23000 + $unsigned($random(seed)) % 42000;
		host.send_cmd(16'(mv));
		chk_mv(setpoint_mv, 16'(mv));
		chk_flag(setpoint_update, 1'b1);
		chk_flag(setpoint_sw_override, 1'b1);
		host.send_cmd(16'(mv));
		chk_flag(setpoint_update, 1'b0);
		setpoint_pin_sample = 10'h100;
		tick(6);
		chk_mv(setpoint_mv, 16'(mv));
		power_cycle(1'b0);
		chk_flag(setpoint_sw_override, 1'b0);
		chk_mv(setpoint_mv, 16'(sp_exp(256)));
		$display("test setpoint done");
		// rs485 mode: address parts, interlock, address bytes refused
		power_cycle(1'b1);
		chk_flag(mode_rs485, 1'b1);
		for (int i = 1; i <= 10; i++) begin
			unit_pos_sample = 10'(unit_cnt(i));
			shelf_pos_sample = 10'(i * 775 / 10);
			power_case(11 - i, 1'b1, 1'b1);
			chk_code(bay_position_code, 4'(i));
			chk_code(slot_position_code, 4'(11 - i));
			chk_code(shelf_position_code, 4'(i));
			chk_flag(rs485_address_valid, 1'b1);
		end
		host.send_addr(7'h00, 1'b0);
		chk_flag(addr_match, 1'b0);
		power_case(11, 1'b0, 1'b0);
		chk_flag(rs485_address_valid, 1'b0);
		shelf_pos_sample = 10'h000;
		tick(6);
		chk_code(shelf_position_code, 4'h0);
		$display("test rs485 done");
		report_and_stop();
	end
endmodule
`default_nettype wire
